// >>> tb.sv
// Self-checking testbench for the word align and stack unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk, sys_rst, acc_valid, acc_word, acc_dword, src_rd, dst_wr, instr_done;
   logic lit_byte_mode, stk_valid, ipl3_bit, mem_rd, mem_wr, addr_error_req, lit_ok;
   logic pop_valid, pc_valid, stk_busy;
   logic [15:0] src_addr, dst_addr, dst_wdata, wreg_old, wreg_result, stk_data, mem_rdata;
   logic [15:0] mem_addr, lit_value, wreg_wdata, stack_ptr, frame_ptr, pop_data;
   logic [9:0] lit_field;
   logic [3:0] lit_opcode;
   logic [7:0] status_low_byte, mem_wdata_even, mem_wdata_odd;
   logic [22:0] pc_in, pc_out;
   was_pkg::was_op_t stk_op;
   logic [31:0] rng_q = 32'h00000058;
   logic [31:0] r, b;
   logic [22:0] exp_q[$];
   int err_count, checks;
   was_unit u_was_unit (.*);
   was_mem_model u_was_mem_model (.*);
   function automatic logic [31:0] xs();
      rng_q = rng_q ^ (rng_q << 13);
      rng_q = rng_q ^ (rng_q >> 17);
      rng_q = rng_q ^ (rng_q << 5);
      return rng_q;
   endfunction
   function automatic logic [15:0] rd16(input logic [15:0] a);
      return {u_was_mem_model.mem[a + 16'h0001], u_was_mem_model.mem[a]};
   endfunction
   task automatic chk(input string n, input logic [22:0] seen, input logic [22:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Stack command, then wait until the sequencer is idle
   task automatic cmd(input was_pkg::was_op_t op, input logic [15:0] d, input logic [31:0] x);
      @(posedge core_clk);
      stk_valid <= 1'b1;
      stk_op <= op;
      stk_data <= d;
      pc_in <= x[22:0];
      status_low_byte <= x[30:23];
      ipl3_bit <= x[31];
      @(posedge core_clk);
      stk_valid <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      while (stk_busy === 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   // One-cycle operand access that also ends its instruction
   task automatic acc(input logic [31:0] x);
      logic e;
      e = (x[0] | x[1]) & (x[2] & x[3] | x[4] & x[5]);
      @(posedge core_clk);
      acc_valid <= 1'b1;
      instr_done <= 1'b1;
      acc_word <= x[0];
      acc_dword <= x[1] & ~x[0];
      src_rd <= x[2];
      src_addr <= {4'h1, x[13:6], 3'h0, x[3]};
      dst_wr <= x[4];
      dst_addr <= {4'h2, x[21:14], 3'h0, x[5]};
      dst_wdata <= x[31:16];
      @(posedge core_clk);
      acc_valid <= 1'b0;
      instr_done <= 1'b0;
      #1;
      chk("addr_error_req", addr_error_req, e);
      @(posedge core_clk);
      #1;
   endtask
   // Random literal and working register traffic every cycle
   always @(posedge core_clk) begin
      b = xs();
      lit_field <= b[9:0];
      lit_byte_mode <= b[10];
      lit_opcode <= b[14:11];
      wreg_old <= b[31:16];
      wreg_result <= b[15:0] ^ b[31:16];
   end
   // Result watcher takes the oldest note for each answer
   always @(negedge core_clk) begin
      if (pop_valid === 1'b1) chk("pop_data", pop_data, exp_q.pop_front());
      if (pc_valid === 1'b1) chk("pc_out", pc_out, exp_q.pop_front());
   end
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      err_count++;
      stop_test();
   end
   initial begin
      {acc_valid, acc_word, acc_dword, src_rd, dst_wr, instr_done, stk_valid} = '0;
      {src_addr, dst_addr, dst_wdata, stk_data, pc_in, status_low_byte, ipl3_bit} = '0;
      {lit_field, lit_byte_mode, lit_opcode, wreg_old, wreg_result} = '0;
      stk_op = was_pkg::WAS_OP_NONE;
      sys_rst = 1'b1;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("stack_ptr", stack_ptr, 16'h0800);
      chk("frame_ptr", frame_ptr, 16'h0000);
      r = xs();
      cmd(was_pkg::WAS_OP_PUSH, r[15:0], '0);
      cmd(was_pkg::WAS_OP_PUSH, r[31:16], '0);
      chk("stack_ptr", stack_ptr, 16'h0804);
      chk("stack word", rd16(16'h0800), r[15:0]);
      exp_q.push_back(r[31:16]);
      cmd(was_pkg::WAS_OP_POP, '0, '0);
      chk("stack_ptr", stack_ptr, 16'h0802);
      cmd(was_pkg::WAS_OP_LINK, 16'h0004, '0);
      chk("frame_ptr", frame_ptr, 16'h0804);
      chk("stack_ptr", stack_ptr, 16'h0808);
      cmd(was_pkg::WAS_OP_UNLINK, '0, '0);
      chk("stack_ptr", stack_ptr, 16'h0802);
      chk("frame_ptr", frame_ptr, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         r = xs();
         cmd(i ? was_pkg::WAS_OP_EXC : was_pkg::WAS_OP_CALL, '0, r);
         chk("stack_ptr", stack_ptr, 16'h0806);
         chk("pc low", rd16(16'h0802), r[15:0]);
         chk("pc high", rd16(16'h0804), i ? {r[30:23], r[31], r[22:16]} : {9'h000, r[22:16]});
         exp_q.push_back(r[22:0]);
         cmd(was_pkg::WAS_OP_RET, '0, '0);
         chk("stack_ptr", stack_ptr, 16'h0802);
      end
      cmd(was_pkg::WAS_OP_SP_WR, 16'h1235, '0);
      chk("stack_ptr", stack_ptr, 16'h1234);
      cmd(was_pkg::WAS_OP_FP_WR, 16'h0ABC, '0);
      chk("frame_ptr", frame_ptr, 16'h0ABC);
      r = xs();
      acc({r[15:0], 16'h0011});
      acc({r[31:22], r[5:0], 16'h0031});
      chk("guarded word", rd16({4'h2, r[5:0], 6'h00}), r[15:0]);
      repeat (16) acc(xs());
      chk("results left", exp_q.size(), 23'h000000);
      stop_test();
   end
endmodule
`default_nettype wire

// >>> was_consts.svh
// Constants for the word align and stack unit
// Notes on behaviour
// R01 - Word operand with odd address raises an address error.
// R02 - Double-word operands follow the same even-address requirement.
// R03 - Address error is signalled only after the instruction completes.
// R04 - Misaligned word read still fetches, with address bit 0 cleared.
// R05 - Misaligned word write is suppressed; error still raised.
// R06 - Low byte sits at the even address, high byte at the odd one.
// R07 - Literal is 10 bits in word mode, low 8 bits in byte mode.
// R08 - Add, add_with_carry_instr, and, ior, return_with_literal_instr, sub, subtract_with_borrow_instr, xor accept the literal.
// R09 - Byte literal above 127 acts as a negative byte, no extra handling.
// R10 - Stack pointer resets to 0x0800.
// R11 - Software may write the stack pointer after reset.
// R12 - Stack grows upward; push writes then increments, pop decrements then reads.
// R13 - Push is a word move to top of stack; pop moves from predecremented address.
// R14 - Each push or pop moves the stack pointer by two bytes.
// R15 - Call pushes pc low word, then zero-extended pc upper seven bits.
// R16 - Exception push merges status low byte and priority bit with pc upper bits.
// R17 - Stack pointer bit 0 is always zero.
// R18 - Frame pointer resets to zero and stays a general register.
// R19 - Frame create and frame remove operations are provided.
// R20 - Frame create pushes frame pointer, copies stack pointer, adds literal.
// R21 - Frame remove copies frame pointer to stack pointer, pops frame pointer.
// R22 - Byte writes to a working register change only its low byte.
// R23 - One address error request covers source and destination addresses.
// R24 - Return pops upper pc word then low word to rebuild the pc.
`ifndef WAS_CONSTS_SVH
`define WAS_CONSTS_SVH
`define WAS_SP_RESET 16'h0800
`define WAS_FP_RESET 16'h0000
`define WAS_WORD_STEP 16'h0002
`define WAS_LIT_W 10
`define WAS_BYTE_W 8
`define WAS_PC_W 23
`define WAS_PC_HI_W 7
`endif

// >>> was_mem_model.sv
// Data memory model on the far side of the unit's memory port
`timescale 1ns/1ps
`default_nettype none
module was_mem_model (
   // Clock
   input wire logic core_clk,
   // Memory port from the unit
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata_even,
   input wire logic [7:0] mem_wdata_odd,
   // Read answer, valid the cycle after a read
   output logic [15:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   initial mem_rdata = 16'h0000;
   always @(posedge core_clk) begin
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata_even;
         mem[mem_addr + 16'h0001] <= mem_wdata_odd;
      end
      if (mem_rd) begin
         mem_rdata <= {mem[mem_addr + 16'h0001], mem[mem_addr]};
      end else begin
         // Stale data scrambled after the read cycle
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule
`default_nettype wire

// >>> was_monitor.sv
// Assertion checker for the word align and stack unit
`timescale 1ns/1ps
`default_nettype none
module was_monitor (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Requests
   input wire logic acc_valid,
   input wire logic acc_word,
   input wire logic acc_dword,
   input wire logic src_rd,
   input wire logic [15:0] src_addr,
   input wire logic dst_wr,
   input wire logic [15:0] dst_addr,
   input wire logic instr_done,
   input wire logic [9:0] lit_field,
   input wire logic lit_byte_mode,
   input wire logic [3:0] lit_opcode,
   input wire logic [15:0] wreg_old,
   input wire logic stk_valid,
   input wire was_pkg::was_op_t stk_op,
   input wire logic [15:0] stk_data,
   // Results
   input wire logic stk_busy,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata_even,
   input wire logic [7:0] mem_wdata_odd,
   input wire logic addr_error_req,
   input wire logic [15:0] lit_value,
   input wire logic lit_ok,
   input wire logic [15:0] wreg_wdata,
   input wire logic [15:0] stack_ptr,
   input wire logic [15:0] frame_ptr,
   input wire logic pc_valid
);
   // Command taken, idle access and misaligned operand decode
   wire logic take = stk_valid && !stk_busy;
   wire logic idle = acc_valid && !stk_valid && !stk_busy;
   wire logic odd = (acc_word || acc_dword) && (src_rd && src_addr[0] || dst_wr && dst_addr[0]);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sp_even_a: assert property (stack_ptr[0] == 1'b0)
      else $error("stack pointer bit 0 set");
   rst_val_a: assert property ($past(sys_rst) |-> stack_ptr == 16'h0800 && frame_ptr == 16'h0000)
      else $error("pointer reset value wrong");
   push_step_a: assert property (take && stk_op == was_pkg::WAS_OP_PUSH |=> mem_wr
      && mem_addr == $past(stack_ptr) && stack_ptr == $past(stack_ptr) + 16'h0002
      && {mem_wdata_odd, mem_wdata_even} == $past(stk_data)) else $error("push wrong");
   pop_step_a: assert property (take && stk_op == was_pkg::WAS_OP_POP |=> mem_rd
      && mem_addr == $past(stack_ptr) - 16'h0002 && stack_ptr == mem_addr) else $error("pop wrong");
   odd_write_a: assert property (idle && dst_wr && (acc_word || acc_dword) && dst_addr[0]
      |=> !mem_wr) else $error("misaligned write not suppressed");
   odd_read_a: assert property (idle && src_rd && acc_word && src_addr[0]
      |=> mem_rd && mem_addr == ($past(src_addr) & 16'hFFFE)) else $error("misaligned read wrong");
   err_raise_a: assert property (acc_valid && instr_done && odd |=> addr_error_req)
      else $error("address error missing");
   err_late_a: assert property (addr_error_req |-> $past(instr_done))
      else $error("address error before instruction end");
   lit_dec_a: assert property (!$past(sys_rst) |-> lit_value[7:0] == $past(lit_field[7:0])
      && lit_ok == ($past(lit_opcode) <= 4'h7
      && (!$past(lit_byte_mode) || $past(lit_field[9:8]) == 2'h0))
      && ($past(lit_byte_mode) || lit_value == {6'h00, $past(lit_field)}))
      else $error("literal decode wrong");
   byte_keep_a: assert property (!$past(sys_rst) && $past(lit_byte_mode)
      |-> wreg_wdata[15:8] == $past(wreg_old[15:8])) else $error("byte write touched high byte");
   cover property (take && stk_op == was_pkg::WAS_OP_CALL);
   cover property (addr_error_req);
   cover property (pc_valid);
endmodule
bind was_unit was_monitor u_was_monitor (.*);
`default_nettype wire

// >>> was_pkg.sv
// Types for the word align and stack unit
package was_pkg;
   // Stack unit operations
   typedef enum logic [3:0] {
      WAS_OP_NONE, WAS_OP_PUSH, WAS_OP_POP, WAS_OP_CALL, WAS_OP_EXC,
      WAS_OP_RET, WAS_OP_LINK, WAS_OP_UNLINK, WAS_OP_SP_WR, WAS_OP_FP_WR
   } was_op_t;
   // Stack sequencer states
   typedef enum logic [2:0] {
      WAS_ST_IDLE, WAS_ST_PUSH2, WAS_ST_POP2, WAS_ST_LINK2, WAS_ST_UNLINK2
   } was_state_t;
endpackage

// >>> was_unit.sv
// Word alignment checker, literal decode and software stack unit
`timescale 1ns/1ps
`default_nettype none
`include "was_consts.svh"
module was_unit (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Operand access request, one cycle per instruction
   input wire logic acc_valid,
   input wire logic acc_word,
   input wire logic acc_dword,
   input wire logic src_rd,
   input wire logic [15:0] src_addr,
   input wire logic dst_wr,
   input wire logic [15:0] dst_addr,
   input wire logic [15:0] dst_wdata,
   input wire logic instr_done,
   // Literal decode
   input wire logic [9:0] lit_field,
   input wire logic lit_byte_mode,
   input wire logic [3:0] lit_opcode,
   input wire logic [15:0] wreg_old,
   input wire logic [15:0] wreg_result,
   // Stack command
   input wire logic stk_valid,
   input wire was_pkg::was_op_t stk_op,
   input wire logic [15:0] stk_data,
   input wire logic [22:0] pc_in,
   input wire logic [7:0] status_low_byte,
   input wire logic ipl3_bit,
   input wire logic [15:0] mem_rdata,
   // Memory port
   output logic mem_rd,
   output logic mem_wr,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata_even,
   output logic [7:0] mem_wdata_odd,
   // Results
   output logic addr_error_req,
   output logic [15:0] lit_value,
   output logic lit_ok,
   output logic [15:0] wreg_wdata,
   output logic [15:0] stack_ptr,
   output logic [15:0] frame_ptr,
   output logic [15:0] pop_data,
   output logic pop_valid,
   output logic [22:0] pc_out,
   output logic pc_valid,
   output logic stk_busy
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic err_pend_q, err_pend_d;
   logic addr_error_q;
   logic [15:0] sp_q, fp_q;
   logic [15:0] sp_d, fp_d;
   was_pkg::was_state_t st_q, st_d;
   logic [15:0] hold_q, hold_d;
   logic [15:0] lo_q;
   logic mem_rd_q, mem_rd_d;
   logic mem_wr_q, mem_wr_d;
   logic [15:0] mem_addr_q, mem_addr_d;
   logic [15:0] mem_wdata_q, mem_wdata_d;
   logic [15:0] lit_q, wreg_q, pop_q;
   logic lit_ok_q, pop_valid_q, pc_valid_q;
   logic [22:0] pc_q;
   logic rd_was_pop_q, rd_was_ret_q, rd_was_ret2_q, rd_was_unl_q;
   // First stage of the read tags, in step with mem_rd
   logic rd_pop1_q, rd_ret1_q, rd_ret21_q, rd_unl1_q;
   // Registered sequencer busy flag
   logic busy_q;

   // ----------------------------------------
   // Alignment check
   // ----------------------------------------
   // R01 odd word address
   // R02 double words share check
   wire wide_acc = acc_word | acc_dword;
   wire src_mis = acc_valid & wide_acc & src_rd & src_addr[0];
   wire dst_mis = acc_valid & wide_acc & dst_wr & dst_addr[0];
   // R23 single combined request
   wire any_mis = src_mis | dst_mis;
   // R04 forced even read address
   wire [15:0] rd_addr_al = {src_addr[15:1], 1'b0};
   // R05 write suppressed
   wire acc_wr_ok = acc_valid & dst_wr & ~dst_mis;

   // ----------------------------------------
   // Literal decode
   // ----------------------------------------
   // R08 opcodes taking the literal
   wire op_lit = (lit_opcode <= 4'h7);
   // R07 byte mode range limit
   wire lit_in_range = ~lit_byte_mode | (lit_field[9:8] == 2'b00);
   // R09 byte sign falls out of bit 7
   wire [15:0] lit_dec = lit_byte_mode ? {8'h00, lit_field[7:0]} : {6'h00, lit_field};
   // R22 byte write keeps high byte
   wire [15:0] wreg_mix = lit_byte_mode ? {wreg_old[15:8], wreg_result[7:0]} : wreg_result;

   // ----------------------------------------
   // Stack addressing
   // ----------------------------------------
   // R14 one word step
   wire [15:0] sp_inc = sp_q + `WAS_WORD_STEP;
   wire [15:0] sp_dec = sp_q - `WAS_WORD_STEP;
   wire [15:0] fp_dec = fp_q - `WAS_WORD_STEP;
   // R15 zero-extended upper pc
   wire [15:0] pc_hi_call = {9'h000, pc_in[22:16]};
   // R16 status merged upper pc
   wire [15:0] pc_hi_exc = {status_low_byte, ipl3_bit, pc_in[22:16]};
   // Commands are only taken while the sequencer is idle
   wire stk_go = stk_valid & (st_q == was_pkg::WAS_ST_IDLE);

   // Error pending until instruction end
   always_comb begin
      err_pend_d = err_pend_q | any_mis;
      // Reported in the done cycle, so nothing carries into the next one
      if (instr_done) begin
         err_pend_d = 1'b0;
      end
   end

   // Stack sequencer and memory port
   always_comb begin
      st_d = st_q;
      sp_d = sp_q;
      fp_d = fp_q;
      hold_d = hold_q;
      mem_rd_d = 1'b0;
      mem_wr_d = 1'b0;
      mem_addr_d = mem_addr_q;
      mem_wdata_d = mem_wdata_q;
      // Plain access; a stack command wins the port, a read wins over a write
      if (acc_valid & src_rd & ~stk_go) begin
         mem_rd_d = 1'b1;
         mem_addr_d = rd_addr_al;
      end
      if (acc_wr_ok & ~stk_go & ~(acc_valid & src_rd)) begin
         mem_wr_d = 1'b1;
         mem_addr_d = dst_addr;
         mem_wdata_d = dst_wdata;
      end
      case (st_q)
         was_pkg::WAS_ST_IDLE: begin
            if (stk_valid) begin
               case (stk_op)
                  // R12 push writes then increments
                  // R13 word move to top of stack
                  was_pkg::WAS_OP_PUSH: begin
                     mem_wr_d = 1'b1;
                     mem_addr_d = sp_q;
                     mem_wdata_d = stk_data;
                     sp_d = sp_inc;
                  end
                  // R12 pop decrements then reads
                  was_pkg::WAS_OP_POP: begin
                     mem_rd_d = 1'b1;
                     mem_addr_d = sp_dec;
                     sp_d = sp_dec;
                  end
                  // R15 low word first
                  was_pkg::WAS_OP_CALL: begin
                     mem_wr_d = 1'b1;
                     mem_addr_d = sp_q;
                     mem_wdata_d = pc_in[15:0];
                     hold_d = pc_hi_call;
                     sp_d = sp_inc;
                     st_d = was_pkg::WAS_ST_PUSH2;
                  end
                  // R16 exception entry push
                  was_pkg::WAS_OP_EXC: begin
                     mem_wr_d = 1'b1;
                     mem_addr_d = sp_q;
                     mem_wdata_d = pc_in[15:0];
                     hold_d = pc_hi_exc;
                     sp_d = sp_inc;
                     st_d = was_pkg::WAS_ST_PUSH2;
                  end
                  // R24 upper word popped first
                  was_pkg::WAS_OP_RET: begin
                     mem_rd_d = 1'b1;
                     mem_addr_d = sp_dec;
                     sp_d = sp_dec;
                     st_d = was_pkg::WAS_ST_POP2;
                  end
                  // R19 R20 push old frame pointer
                  was_pkg::WAS_OP_LINK: begin
                     mem_wr_d = 1'b1;
                     mem_addr_d = sp_q;
                     mem_wdata_d = fp_q;
                     fp_d = sp_inc;
                     sp_d = sp_inc;
                     hold_d = {stk_data[15:1], 1'b0};
                     st_d = was_pkg::WAS_ST_LINK2;
                  end
                  // R21 stack pointer from frame pointer, pop
                  was_pkg::WAS_OP_UNLINK: begin
                     mem_rd_d = 1'b1;
                     mem_addr_d = fp_dec;
                     sp_d = fp_dec;
                     st_d = was_pkg::WAS_ST_UNLINK2;
                  end
                  // R11 software write
                  was_pkg::WAS_OP_SP_WR: begin
                     sp_d = stk_data;
                  end
                  // R18 general register use
                  was_pkg::WAS_OP_FP_WR: begin
                     fp_d = stk_data;
                  end
                  default: begin
                  end
               endcase
            end
         end
         was_pkg::WAS_ST_PUSH2: begin
            mem_wr_d = 1'b1;
            mem_addr_d = sp_q;
            mem_wdata_d = hold_q;
            sp_d = sp_inc;
            st_d = was_pkg::WAS_ST_IDLE;
         end
         was_pkg::WAS_ST_POP2: begin
            mem_rd_d = 1'b1;
            mem_addr_d = sp_dec;
            sp_d = sp_dec;
            st_d = was_pkg::WAS_ST_IDLE;
         end
         was_pkg::WAS_ST_LINK2: begin
            // R20 reserve local bytes
            sp_d = sp_q + hold_q;
            st_d = was_pkg::WAS_ST_IDLE;
         end
         was_pkg::WAS_ST_UNLINK2: begin
            // Stay busy until the saved frame pointer word returns
            if (rd_was_unl_q) begin
               st_d = was_pkg::WAS_ST_IDLE;
            end
         end
         default: begin
            st_d = was_pkg::WAS_ST_IDLE;
         end
      endcase
      // R17 bit 0 held clear
      sp_d[0] = 1'b0;
   end

   // Pointer and sequencer registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         // R10 stack pointer reset
         sp_q <= `WAS_SP_RESET;
         // R18 frame pointer reset
         fp_q <= `WAS_FP_RESET;
         st_q <= was_pkg::WAS_ST_IDLE;
         hold_q <= 16'h0000;
         busy_q <= 1'b0;
      end else begin
         sp_q <= sp_d;
         // R21 saved frame pointer lands two cycles after its read
         fp_q <= (st_q == was_pkg::WAS_ST_UNLINK2 && rd_was_unl_q) ? mem_rdata : fp_d;
         st_q <= st_d;
         hold_q <= hold_d;
         busy_q <= (st_d != was_pkg::WAS_ST_IDLE);
      end
   end

   // Memory port registers; data memory answers a cycle after mem_rd
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         mem_wdata_q <= 16'h0000;
      end else begin
         mem_rd_q <= mem_rd_d;
         mem_wr_q <= mem_wr_d;
         mem_addr_q <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d;
      end
   end

   // Read return tagging: first stage rides with mem_rd, second with mem_rdata
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_pop1_q <= 1'b0;
         rd_ret1_q <= 1'b0;
         rd_ret21_q <= 1'b0;
         rd_unl1_q <= 1'b0;
         rd_was_pop_q <= 1'b0;
         rd_was_ret_q <= 1'b0;
         rd_was_ret2_q <= 1'b0;
         rd_was_unl_q <= 1'b0;
      end else begin
         rd_pop1_q <= stk_go & (stk_op == was_pkg::WAS_OP_POP);
         rd_ret1_q <= stk_go & (stk_op == was_pkg::WAS_OP_RET);
         rd_ret21_q <= (st_q == was_pkg::WAS_ST_POP2);
         rd_unl1_q <= stk_go & (stk_op == was_pkg::WAS_OP_UNLINK);
         rd_was_pop_q <= rd_pop1_q;
         rd_was_ret_q <= rd_ret1_q;
         rd_was_ret2_q <= rd_ret21_q;
         rd_was_unl_q <= rd_unl1_q;
      end
   end

   // Popped data and rebuilt pc
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pop_q <= 16'h0000;
         pop_valid_q <= 1'b0;
         lo_q <= 16'h0000;
         pc_q <= 23'h000000;
         pc_valid_q <= 1'b0;
      end else begin
         pop_valid_q <= rd_was_pop_q;
         if (rd_was_pop_q) begin
            pop_q <= mem_rdata;
         end
         if (rd_was_ret_q) begin
            lo_q <= mem_rdata;
         end
         pc_valid_q <= rd_was_ret2_q;
         // R24 reassemble pc
         if (rd_was_ret2_q) begin
            pc_q <= {lo_q[6:0], mem_rdata};
         end
      end
   end

   // Address error and literal outputs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         err_pend_q <= 1'b0;
         addr_error_q <= 1'b0;
         lit_q <= 16'h0000;
         lit_ok_q <= 1'b0;
         wreg_q <= 16'h0000;
      end else begin
         err_pend_q <= err_pend_d;
         // R03 raised at instruction end
         addr_error_q <= instr_done & (err_pend_q | any_mis);
         lit_q <= lit_dec;
         lit_ok_q <= op_lit & lit_in_range;
         wreg_q <= wreg_mix;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mem_rd = mem_rd_q;
   assign mem_wr = mem_wr_q;
   assign mem_addr = mem_addr_q;
   // R06 little-endian byte lanes
   assign mem_wdata_even = mem_wdata_q[7:0];
   assign mem_wdata_odd = mem_wdata_q[15:8];
   assign addr_error_req = addr_error_q;
   assign lit_value = lit_q;
   assign lit_ok = lit_ok_q;
   assign wreg_wdata = wreg_q;
   assign stack_ptr = sp_q;
   assign frame_ptr = fp_q;
   assign pop_data = pop_q;
   assign pop_valid = pop_valid_q;
   assign pc_out = pc_q;
   assign pc_valid = pc_valid_q;
   assign stk_busy = busy_q;
endmodule
`default_nettype wire
